// ==== dv/host_model.sv ====
module host_model
  import pm_state_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Requests toward the block.
  output cfg_req_type cfg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // One access per call; fields are scrambled after release so stale values never pass.
  task automatic acc(input logic w, input logic [1:0] f, input logic [7:0] a,
    input logic [15:0] d);
    @(posedge clk_sys);
    cfg_req <= '{rd: !w, wr: w, func: f, addr: a, wdata: d};
    @(posedge clk_sys);
    cfg_req <= '{rd: 1'h0, wr: 1'h0, func: ~f, addr: ~a, wdata: ~d};
  endtask
  initial cfg_req = '0;
endmodule

// ==== dv/pm_state_checker.sv ====
module pm_state_checker
  import pm_state_pkg::*;
(
  // Clock and resets.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic global_reset,
  input wire logic host_bus_reset,
  // Host access and results.
  input wire cfg_req_type cfg_req,
  input wire logic [15:0] cfg_rdata,
  input wire logic [1:0] irq_src,
  input wire logic [1:0] wake_event,
  input wire logic [1:0] irq_out,
  input wire logic gpe_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Checks on the outputs of both functions and on bridge function reads.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic rd0;
  // A read of the bridge function taken at this edge.
  assign rd0 = cfg_req.rd && ce && cfg_req.func == 2'h0;
  gr_quiet_a:
    assert property (global_reset |-> !gpe_event && wake_event == 2'h0 && irq_out == 2'h0)
    else $error("Outputs active in global reset.");
  irq_gate_a:
    assert property ((irq_out & ~irq_src) == 2'h0)
    else $error("Interrupt without a source.");
  bus_uninit_a:
    assert property (host_bus_reset && ce |=> irq_out == 2'h0 && wake_event == 2'h0)
    else $error("Events after bus reset.");
  status_flag_a:
    assert property (rd0 && cfg_req.addr == 8'h06 |=> cfg_rdata == 16'h0010)
    else $error("Status word wrong.");
  cap_ptr_a:
    assert property (rd0 && cfg_req.addr == 8'h14 |=> cfg_rdata == 16'h00a0)
    else $error("Capability pointer wrong.");
  cap_head_a:
    assert property (rd0 && cfg_req.addr == 8'ha0 |=> cfg_rdata == 16'h0001)
    else $error("Capability header wrong.");
  pmc_value_a:
    assert property (rd0 && cfg_req.addr == 8'ha2 |=> cfg_rdata == 16'h7e02)
    else $error("Capabilities word wrong.");
  unmapped_zero_a:
    assert property (rd0 && cfg_req.addr == 8'hfe |=> cfg_rdata == 16'h0000)
    else $error("Unmapped read not zero.");
  // Main scenarios reached.
  cover property (gpe_event);
  cover property (wake_event[0]);
  cover property (irq_out[0]);
endmodule

bind pm_state_ctrl pm_state_checker pm_state_checker_inst (.clk_sys, .rst, .ce, .global_reset,
  .host_bus_reset, .cfg_req, .cfg_rdata, .irq_src, .wake_event, .irq_out, .gpe_event);

// ==== dv/pm_state_ctrl_tb.sv ====
module pm_state_ctrl_tb;
  import pm_state_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, ce = 1, global_reset = 0, host_bus_reset = 0, power_removed = 0;
  logic [1:0] wake_src = 0, irq_src = 0, wake_event, irq_out, secondary_bus_state;
  logic [7:0] gpe_src = 0, v;
  logic [15:0] cfg_rdata, exp_q[$];
  logic gpe_event, pend = 0;
  cfg_req_type cfg_req;
  int failures = 0, cmp_count = 0, seed = 32'hb7dc;
  // ====================
  // Clock, design and host.
  always #2.5 clk_sys = ~clk_sys;
  pm_state_ctrl pm_state_ctrl_inst (.*);
  host_model host_model_inst (.clk_sys, .cfg_req);
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] f, input logic [7:0] a, input logic [15:0] d);
    host_model_inst.acc(1'h1, f, a, d);
  endtask
  task automatic rd(input logic [1:0] f, input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host_model_inst.acc(1'h0, f, a, 16'h0);
  endtask
  task automatic bus_rst();
    @(posedge clk_sys) host_bus_reset <= 1'h1;
    @(posedge clk_sys) host_bus_reset <= 1'h0;
  endtask
  task automatic end_sim();
    $display("compares=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Read data lands one edge after the request, so it is taken at the next falling edge.
  always @(negedge clk_sys)
  begin
    if (pend)
      chk(cfg_rdata, exp_q.pop_front());
    pend = cfg_req.rd;
  end
  // A hang is cut short well past the expected run of about half a microsecond.
  initial
  begin
    #20000;
    failures++;
    end_sim();
  end
  // ====================
  // Scenarios.
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    rd(2'h0, 8'h06, 16'h0010);
    rd(2'h0, 8'h14, 16'h00a0);
    rd(2'h0, 8'ha0, 16'h0001);
    rd(2'h2, 8'h44, 16'h0001);
    rd(2'h0, 8'ha2, 16'h7e02);
    rd(2'h0, 8'hfe, 16'h0000);
    $display("constants done");
    @(posedge clk_sys) irq_src <= 2'h3;
    repeat (2) @(posedge clk_sys);
    chk(16'(irq_out), 16'h0);
    wr(2'h0, 8'h04, 16'h0003);
    wr(2'h2, 8'h04, 16'h0001);
    @(negedge clk_sys) chk(16'(irq_out), 16'h1);
    wr(2'h2, 8'h04, 16'h0003);
    for (int s = 1; s <= 4; s++)
    begin
      wr(2'h0, 8'ha4, 16'(s % 4));
      wr(2'h2, 8'h48, 16'(s % 4));
      rd(2'h0, 8'ha4, 16'(s % 4));
      rd(2'h2, 8'h48, 16'(s % 4));
      chk(16'(secondary_bus_state), 16'(s % 4));
    end
    $display("states done");
    wr(2'h0, 8'ha4, 16'h0100);
    @(posedge clk_sys) wake_src <= 2'h1;
    @(posedge clk_sys) wake_src <= 2'h0;
    @(negedge clk_sys) chk(16'(wake_event), 16'h1);
    bus_rst();
    rd(2'h0, 8'ha4, 16'h8100);
    wr(2'h0, 8'ha4, 16'h0000);
    bus_rst();
    rd(2'h0, 8'ha4, 16'h0000);
    $display("wake done");
    v = 8'($random(seed)) | 8'h01;
    wr(2'h0, 8'h88, 16'hff00);
    @(posedge clk_sys) gpe_src <= v;
    @(posedge clk_sys) gpe_src <= 8'h00;
    bus_rst();
    @(negedge clk_sys) chk(16'(gpe_event), 16'h1);
    rd(2'h0, 8'h88, {8'hdf, v & 8'hdf});
    wr(2'h0, 8'h88, 16'h00ff);
    @(negedge clk_sys) chk(16'(gpe_event), 16'h0);
    $display("events done");
    wr(2'h0, 8'h04, 16'h0003);
    @(posedge clk_sys) power_removed <= 1'h1;
    @(posedge clk_sys) host_bus_reset <= 1'h1;
    @(posedge clk_sys) power_removed <= 1'h0;
    @(posedge clk_sys) host_bus_reset <= 1'h0;
    // The D3cold exit is taken at the first edge that sees the release.
    @(posedge clk_sys);
    @(negedge clk_sys) chk(16'(irq_out), 16'h0);
    wr(2'h0, 8'h04, 16'h0003);
    wr(2'h0, 8'h88, 16'hff00);
    @(negedge clk_sys) chk(16'(irq_out), 16'h1);
    @(posedge clk_sys) global_reset <= 1'h1;
    @(negedge clk_sys) chk(16'(irq_out), 16'h0);
    @(posedge clk_sys) global_reset <= 1'h0;
    rd(2'h0, 8'h88, 16'h0000);
    $display("resets done");
    // A write while the clock enable is low must leave no trace.
    @(posedge clk_sys) ce <= 1'h0;
    wr(2'h0, 8'h04, 16'h0003);
    @(posedge clk_sys) ce <= 1'h1;
    rd(2'h0, 8'h04, 16'h0000);
    $display("freeze done");
    repeat (2) @(posedge clk_sys);
    end_sim();
  end
endmodule

// ==== rtl/pm_state_ctrl.sv ====
`include "pm_state_regs.svh"

module pm_state_ctrl
  import pm_state_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Resets from the host bus, active high here.
  input wire logic global_reset,
  input wire logic host_bus_reset,
  // Main power lost, function enters D3cold.
  input wire logic power_removed,
  // Configuration access, 16-bit aligned words; func 0 bridge, 2 host controller.
  input wire cfg_req_type cfg_req,
  output logic [15:0] cfg_rdata,
  // Wake sources and general event inputs.
  input wire logic [1:0] wake_src,
  input wire logic [7:0] gpe_src,
  input wire logic [1:0] irq_src,
  // Results.
  output logic [1:0] wake_event,
  output logic [1:0] irq_out,
  output logic gpe_event,
  output logic [1:0] secondary_bus_state
);

  // ==========================================================
  // Resets
  // ==========================================================
  // Global reset wipes all; a bus reset wipes ordinary bits.
  logic hard_rst;
  logic soft_rst;
  assign hard_rst = rst | global_reset;
  assign soft_rst = hard_rst | host_bus_reset;

  logic [1:0] io_en_q;
  logic [1:0] mem_en_q;
  logic [1:0] wake_en_q;
  logic [1:0] wake_sts_q;
  logic [1:0] pstate_q [2];
  fn_state_type fn_q [2];
  logic [7:0] gpe_sts_q;
  logic [7:0] gpe_en_q;
  logic host_bus_reset_q;

  logic wr_ok;
  assign wr_ok = ce & cfg_req.wr;

  // Tracks release of the bus reset for the D3cold exit.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      host_bus_reset_q <= 1'b0;
    else if (ce)
      host_bus_reset_q <= host_bus_reset;
  end

  // ==========================================================
  // Per-function state
  // ==========================================================
  // Index 0 is the bridge, index 1 the host controller.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : fn_gen
      localparam logic [1:0] fnum = (g == 0) ? 2'h0 : 2'h2;
      localparam logic [7:0] csr_ofs = (g == 0) ? `OFS_BR_CSR : `OFS_HC_CSR;
      logic hit_cmd;
      logic hit_csr;
      assign hit_cmd = wr_ok && cfg_req.func == fnum && cfg_req.addr == `OFS_COMMAND;
      assign hit_csr = wr_ok && cfg_req.func == fnum && cfg_req.addr == csr_ofs;

      // Command enables are ordinary bits, cleared by either reset.
      always_ff @(posedge clk_sys or posedge soft_rst)
      begin
        if (soft_rst)
        begin
          io_en_q[g] <= 1'b0;
          mem_en_q[g] <= 1'b0;
        end
        else if (ce && hit_cmd)
        begin
          io_en_q[g] <= cfg_req.wdata[`BIT_IO_EN];
          mem_en_q[g] <= cfg_req.wdata[`BIT_MEM_EN];
        end
      end

      // Wake enable is cleared only by global reset.
      always_ff @(posedge clk_sys or posedge hard_rst)
      begin
        if (hard_rst)
          wake_en_q[g] <= 1'b0;
        else if (hit_csr)
          wake_en_q[g] <= cfg_req.wdata[`BIT_WAKE_EN];
      end

      // Wake status is context: a bus reset clears it only while wake is off.
      always_ff @(posedge clk_sys or posedge hard_rst)
      begin
        if (hard_rst)
          wake_sts_q[g] <= 1'b0;
        else if (ce)
        begin
          if (host_bus_reset && !wake_en_q[g])
            wake_sts_q[g] <= 1'b0;
          else if (wake_src[g] && fn_q[g] != fn_d0_uninit)
            wake_sts_q[g] <= 1'b1;
          else if (hit_csr && cfg_req.wdata[`BIT_WAKE_STS] && !host_bus_reset)
            wake_sts_q[g] <= 1'b0;
        end
      end

      // Power-state machine.
      always_ff @(posedge clk_sys or posedge hard_rst)
      begin
        if (hard_rst)
        begin
          fn_q[g] <= fn_d0_uninit;
          pstate_q[g] <= pstate_d0;
        end
        else if (ce)
        begin
          if (power_removed)
            fn_q[g] <= fn_d3cold;
          else
            case (fn_q[g])
              fn_d3cold:
              begin
                if (host_bus_reset_q && !host_bus_reset)
                begin
                  fn_q[g] <= fn_d0_uninit;
                  pstate_q[g] <= pstate_d0;
                end
              end
              fn_d0_uninit:
              begin
                if (host_bus_reset)
                  pstate_q[g] <= pstate_d0;
                else if (io_en_q[g] && mem_en_q[g])
                  fn_q[g] <= fn_d0_active;
              end
              fn_d0_active, fn_d1, fn_d2, fn_d3hot:
              begin
                if (host_bus_reset)
                begin
                  fn_q[g] <= fn_d0_uninit;
                  pstate_q[g] <= pstate_d0;
                end
                else if (hit_csr)
                begin
                  pstate_q[g] <= cfg_req.wdata[1:0];
                  case (cfg_req.wdata[1:0])
                    pstate_d1: fn_q[g] <= fn_d1;
                    pstate_d2: fn_q[g] <= fn_d2;
                    pstate_d3hot: fn_q[g] <= fn_d3hot;
                    default: fn_q[g] <= fn_d0_active;
                  endcase
                end
              end
              default: fn_q[g] <= fn_d0_uninit;
            endcase
        end
      end

      // Events are held back while uninitialized.
      assign wake_event[g] = wake_sts_q[g] & wake_en_q[g] & (fn_q[g] != fn_d0_uninit);
      assign irq_out[g] = irq_src[g] & (fn_q[g] == fn_d0_active);
    end
  endgenerate

  // ==========================================================
  // General-purpose events
  // ==========================================================
  // Global-reset-only; set wins over a write-one clear.
  logic gpe_sts_wr;
  logic gpe_en_wr;
  assign gpe_sts_wr = wr_ok && cfg_req.func == 2'h0 && cfg_req.addr == `OFS_GPE_STS;
  assign gpe_en_wr = wr_ok && cfg_req.func == 2'h0 && cfg_req.addr == `OFS_GPE_STS;

  always_ff @(posedge clk_sys or posedge hard_rst)
  begin
    if (hard_rst)
      gpe_sts_q <= 8'h00;
    else if (ce)
    begin
      if (gpe_sts_wr)
        gpe_sts_q <= ((gpe_sts_q & ~cfg_req.wdata[7:0]) | gpe_src) & `GPE_MASK;
      else
        gpe_sts_q <= (gpe_sts_q | gpe_src) & `GPE_MASK;
    end
  end

  // Enables live in the upper byte of the 88h word (byte 89h).
  always_ff @(posedge clk_sys or posedge hard_rst)
  begin
    if (hard_rst)
      gpe_en_q <= 8'h00;
    else if (ce && gpe_en_wr)
      gpe_en_q <= cfg_req.wdata[15:8] & `GPE_MASK;
  end

  assign gpe_event = |(gpe_sts_q & gpe_en_q);

  // Secondary bus follows bridge device state: D0->B0 .. D3->B3.
  assign secondary_bus_state = pstate_q[0];

  // ==========================================================
  // Read path
  // ==========================================================
  // Registered read data; unmapped words read zero.
  logic [15:0] rd_d;
  always_comb
  begin
    rd_d = 16'h0000;
    if (cfg_req.func == 2'h0)
      case (cfg_req.addr)
        `OFS_COMMAND: rd_d = {14'h0000, mem_en_q[0], io_en_q[0]};
        `OFS_STATUS: rd_d = 16'h0010;
        `OFS_CAP_PTR: rd_d = {8'h00, `OFS_BR_CAP};
        `OFS_BR_CAP: rd_d = {`CAP_NEXT_NONE, `CAP_ID_PM};
        `OFS_BR_PMC: rd_d = `PMC_VALUE;
        `OFS_BR_CSR: rd_d = {wake_sts_q[0], 6'h00, wake_en_q[0], 6'h00, pstate_q[0]};
        `OFS_GPE_STS: rd_d = {gpe_en_q, gpe_sts_q};
        default: rd_d = 16'h0000;
      endcase
    else if (cfg_req.func == 2'h2)
      case (cfg_req.addr)
        `OFS_COMMAND: rd_d = {14'h0000, mem_en_q[1], io_en_q[1]};
        `OFS_STATUS: rd_d = 16'h0010;
        `OFS_HC_CAP: rd_d = {`CAP_NEXT_NONE, `CAP_ID_PM};
        `OFS_HC_CSR: rd_d = {wake_sts_q[1], 6'h00, wake_en_q[1], 6'h00, pstate_q[1]};
        default: rd_d = 16'h0000;
      endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfg_rdata <= 16'h0000;
    else if (ce && cfg_req.rd)
      cfg_rdata <= rd_d;
  end

endmodule

// ==== rtl/pm_state_pkg.sv ====
package pm_state_pkg;
  // Visible power-state field encoding.
  typedef enum logic [1:0] {
    pstate_d0 = 2'h0,
    pstate_d1 = 2'h1,
    pstate_d2 = 2'h2,
    pstate_d3hot = 2'h3
  } pstate_type;

  // Internal per-function state.
  typedef enum logic [5:0] {
    fn_d0_uninit = 6'h01,
    fn_d0_active = 6'h02,
    fn_d1 = 6'h04,
    fn_d2 = 6'h08,
    fn_d3hot = 6'h10,
    fn_d3cold = 6'h20
  } fn_state_type;

  // Configuration access from the host side.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] func;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cfg_req_type;
endpackage

// ==== rtl/pm_state_regs.svh ====
`ifndef PM_STATE_REGS_SVH
`define PM_STATE_REGS_SVH
// What this block does
// - No wake events or interrupts in uninitialized D0.
// - IO and memory enable both set gives active D0.
// - D3cold leaves to uninitialized D0 at bus-reset release.
// - Global reset forces uninitialized D0 at once.
// - Power-state field encodes D0, D1, D2, D3hot only.
// - Capability-list flag in status reads one.
// - Bridge capabilities pointer at offset 14h.
// - Capability block starts ID 01h, then next pointer.
// - Last capability next pointer reads zero.
// - Capabilities register reported at offset A2h.
// - Bridge control/status at A4h sets state, wake events.
// - Host controller states, control/status at 48h.
// - Global reset returns everything to defaults.
// - Wake enabled: bus reset keeps wake context.
// - Wake disabled: bus reset clears wake context.
// - Event status at 88h, enables at 89h.
// - Status and enable together raise host event.
// - Secondary bus state follows bridge device state.
// - Wake enable at bit 8; context cleared by global reset.
// - Global-reset-only bits ignore host bus reset.

// Configuration offsets (byte addresses).
`define OFS_COMMAND 8'h04
`define OFS_STATUS 8'h06
`define OFS_CAP_PTR 8'h14
`define OFS_HC_CAP 8'h44
`define OFS_HC_CSR 8'h48
`define OFS_GPE_STS 8'h88
`define OFS_GPE_EN 8'h89
`define OFS_BR_CAP 8'ha0
`define OFS_BR_PMC 8'ha2
`define OFS_BR_CSR 8'ha4
// Field positions.
`define BIT_IO_EN 0
`define BIT_MEM_EN 1
`define BIT_CAP_LIST 4
`define BIT_WAKE_EN 8
`define BIT_WAKE_STS 15
// Constant register contents.
`define CAP_ID_PM 8'h01
`define CAP_NEXT_NONE 8'h00
`define PMC_VALUE 16'h7e02
`define GPE_MASK 8'hdf
`endif
